/* File: hw/trace_sampler.sv */
// Trace memory sampler with AXI4-Lite register access
// Operation
// - Arm bit starts sampling, set by tool
// - Trigger bit records data, program or tool
// - Active flag high throughout tracing
// - Full flag set when memory filled
// - Sample holds twelve bits, three words
// - Each marker execution takes one sample
// - Without markers, sample at program end
// - Timed mode samples at fixed interval
// - Marker ignores rung condition, only bits
// - Signed delay shifts trace start point
// - Trigger places start mark using delay
// - Circular write wraps until start mark
// - Skipped marker in jump takes nothing
// - Trace memory readable by host
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module trace_sampler (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trace_sample_point,
   input wire logic jump_skip,
   input wire logic program_end,
   input wire logic program_trigger,
   input wire logic [11:0] trace_bits,
   input wire logic [15:0] trace_word0,
   input wire logic [15:0] trace_word1,
   input wire logic [15:0] trace_word2,
   output logic tracing_active_flag,
   output logic trace_full_flag,
   output logic irq
);
   // Synchronised program-side inputs
   logic [2:0] ev_sync;
   trace_pkg::events_t ev;
   logic trig_pin;
   logic [59:0] data_sync;
   trace_pkg::sample_t sample;

   sync2 #(.W(4)) u_sync_ev (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({program_trigger, trace_sample_point, jump_skip, program_end}),
      .q({trig_pin, ev_sync})
   );
   sync2 #(.W(60)) u_sync_data (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({trace_word2, trace_word1, trace_word0, trace_bits}),
      .q(data_sync)
   );

   assign ev = trace_pkg::events_t'(ev_sync);
   assign sample = trace_pkg::sample_t'(data_sync);

   // Edge detection of synchronised strobes
   logic marker_prev_reg;
   logic end_prev_reg;
   logic marker_edge;
   logic end_edge;
   assign marker_edge = ev.marker && !marker_prev_reg;
   assign end_edge = ev.program_end && !end_prev_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         marker_prev_reg <= 1'b0;
         end_prev_reg <= 1'b0;
      end else begin
         marker_prev_reg <= ev.marker;
         end_prev_reg <= ev.program_end;
      end
   end

   // Software registers
   logic arm_reg;
   logic trig_reg;
   logic [15:0] delay_reg;
   logic [31:0] interval_reg;
   logic [1:0] mode_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic [trace_pkg::AW-1:0] rd_addr_reg;

   // Trace engine state
   trace_pkg::state_t state_reg;
   trace_pkg::state_t state_next;
   logic [trace_pkg::AW-1:0] wptr_reg;
   logic [trace_pkg::AW-1:0] mark_reg;
   logic [15:0] pend_reg;
   logic [31:0] tick_reg;
   logic full_reg;

   // Sample source selection
   logic timed_mode;
   logic marker_mode;
   logic timer_hit;
   logic take_sample;
   assign timed_mode = mode_reg[trace_pkg::MODE_TIMED];
   assign marker_mode = mode_reg[trace_pkg::MODE_MARKER];
   assign timer_hit = (tick_reg >= interval_reg) && (interval_reg != 32'h0000_0000);
   assign take_sample = arm_reg && (state_reg != trace_pkg::ST_DONE) &&
      (timed_mode ? timer_hit :
       marker_mode ? (marker_edge && !ev.marker_skipped) :
       end_edge);

   // Trigger combines program and tool sources
   logic trig_fire;
   logic trig_seen_reg;
   assign trig_fire = (trig_reg || trig_pin) && !trig_seen_reg;

   // Start mark from signed delay
   logic signed [15:0] delay_s;
   logic [trace_pkg::AW-1:0] neg_mark;
   logic [15:0] neg_mag;
   assign delay_s = $signed(delay_reg);
   assign neg_mag = 16'(-delay_s);
   assign neg_mark = wptr_reg - trace_pkg::AW'(neg_mag);

   logic at_mark;
   logic [trace_pkg::AW-1:0] wptr_inc;
   assign wptr_inc = wptr_reg + 1'b1;
   assign at_mark = (state_reg == trace_pkg::ST_RECORDING) && take_sample && (wptr_inc == mark_reg) &&
      (pend_reg == 16'h0000);

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         trace_pkg::ST_IDLE: begin
            if (arm_reg) begin
               state_next = trace_pkg::ST_SAMPLING;
            end
         end
         trace_pkg::ST_SAMPLING: begin
            if (!arm_reg) begin
               state_next = trace_pkg::ST_IDLE;
            end else if (trig_fire) begin
               state_next = trace_pkg::ST_RECORDING;
            end
         end
         trace_pkg::ST_RECORDING: begin
            if (at_mark) begin
               state_next = trace_pkg::ST_DONE;
            end else if (!arm_reg) begin
               state_next = trace_pkg::ST_IDLE;
            end
         end
         trace_pkg::ST_DONE: begin
            if (!arm_reg) begin
               state_next = trace_pkg::ST_IDLE;
            end
         end
         default: state_next = trace_pkg::ST_IDLE;
      endcase
   end

   // Memory write and marking
   logic mem_we;
   assign mem_we = take_sample;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= trace_pkg::ST_IDLE;
         wptr_reg <= '0;
         mark_reg <= '0;
         pend_reg <= 16'h0000;
         full_reg <= 1'b0;
         trig_seen_reg <= 1'b0;
         tick_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         tick_reg <= (timer_hit || !arm_reg) ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
         if (mem_we) begin
            wptr_reg <= wptr_inc;
         end
         if (state_reg == trace_pkg::ST_IDLE && arm_reg) begin
            full_reg <= 1'b0;
            trig_seen_reg <= 1'b0;
            wptr_reg <= '0;
         end
         if (state_reg == trace_pkg::ST_SAMPLING && trig_fire) begin
            trig_seen_reg <= 1'b1;
            if (delay_s < 0) begin
               mark_reg <= neg_mark;
               pend_reg <= 16'h0000;
            end else begin
               mark_reg <= wptr_reg + trace_pkg::AW'(delay_reg);
               pend_reg <= delay_reg;
            end
         end
         // Positive delay: count off the samples before the trace starts
         if (state_reg == trace_pkg::ST_RECORDING && take_sample && pend_reg != 16'h0000) begin
            pend_reg <= pend_reg - 16'h0001;
         end
         if (at_mark) begin
            full_reg <= 1'b1;
         end
      end
   end

   assign tracing_active_flag = (state_reg == trace_pkg::ST_RECORDING);
   assign trace_full_flag = full_reg;

   trace_pkg::sample_t rd_data;
   trace_ram u_ram (
      .aclk(aclk),
      .we(mem_we),
      .waddr(wptr_reg),
      .wdata(sample),
      .raddr(rd_addr_reg),
      .rdata(rd_data)
   );

   // AXI4-Lite write channel capture
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic do_write;
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign do_write = aw_held_reg && w_held_reg;

   logic wr_known;
   assign wr_known = (awaddr_reg <= trace_pkg::OFF_RD_ADDR) && (awaddr_reg[1:0] == 2'b00);

   // Interrupt events
   logic [1:0] irq_set;
   assign irq_set = {at_mark, (state_reg == trace_pkg::ST_SAMPLING) && trig_fire};
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= trace_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? trace_pkg::RESP_OKAY : trace_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes; hardware events win over clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm_reg <= 1'b0;
         trig_reg <= 1'b0;
         delay_reg <= trace_pkg::DELAY_RST;
         interval_reg <= trace_pkg::INTERVAL_RST;
         mode_reg <= trace_pkg::MODE_RST;
         irq_stat_reg <= 2'b00;
         irq_mask_reg <= 2'b00;
         rd_addr_reg <= '0;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
         if (do_write && wr_known) begin
            case (awaddr_reg)
               trace_pkg::OFF_CTRL: begin
                  if (wstrb_reg[1]) begin
                     arm_reg <= wdata_reg[trace_pkg::BIT_ARM];
                     trig_reg <= wdata_reg[trace_pkg::BIT_TRIG];
                  end
               end
               trace_pkg::OFF_DELAY: begin
                  if (wstrb_reg[0]) delay_reg[7:0] <= wdata_reg[7:0];
                  if (wstrb_reg[1]) delay_reg[15:8] <= wdata_reg[15:8];
               end
               trace_pkg::OFF_INTERVAL: interval_reg <= wdata_reg;
               trace_pkg::OFF_MODE: mode_reg <= wdata_reg[1:0];
               trace_pkg::OFF_IRQ_STAT: irq_stat_reg <= (irq_stat_reg & ~wdata_reg[1:0]) | irq_set;
               trace_pkg::OFF_IRQ_MASK: irq_mask_reg <= wdata_reg[1:0];
               trace_pkg::OFF_RD_ADDR: rd_addr_reg <= wdata_reg[trace_pkg::AW-1:0];
               default: ;
            endcase
         end
      end
   end

   // AXI4-Lite read channel
   logic [7:0] ar_off;
   logic [31:0] rd_mux;
   logic rd_known;
   assign ar_off = s_axi_araddr[7:0];
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_known = (ar_off <= trace_pkg::OFF_POINTERS) && (ar_off[1:0] == 2'b00);
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (ar_off)
         trace_pkg::OFF_CTRL: rd_mux = {16'h0000, arm_reg, trig_reg, tracing_active_flag, full_reg, 12'h000};
         trace_pkg::OFF_DELAY: rd_mux = {16'h0000, delay_reg};
         trace_pkg::OFF_INTERVAL: rd_mux = interval_reg;
         trace_pkg::OFF_MODE: rd_mux = {30'h0000_0000, mode_reg};
         trace_pkg::OFF_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat_reg};
         trace_pkg::OFF_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask_reg};
         trace_pkg::OFF_RD_ADDR: rd_mux = {24'h00_0000, rd_addr_reg};
         trace_pkg::OFF_RD_LO: rd_mux = {rd_data.word0, 4'h0, rd_data.bits};
         trace_pkg::OFF_RD_MID: rd_mux = {16'h0000, rd_data.word1};
         trace_pkg::OFF_RD_HI: rd_mux = {16'h0000, rd_data.word2};
         trace_pkg::OFF_POINTERS: rd_mux = {pend_reg, mark_reg, wptr_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= trace_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_known ? trace_pkg::RESP_OKAY : trace_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // trace_sampler

/* File: hw/trace_pkg.sv */
// Package with register map, fields and types of the trace memory sampler
package trace_pkg;
   localparam int DEPTH = 256;
   localparam int AW = 8;
   localparam int BITS_N = 12;
   localparam int WORDS_N = 3;
   localparam int SAMPLE_W = 60;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DELAY = 8'h04;
   localparam logic [7:0] OFF_INTERVAL = 8'h08;
   localparam logic [7:0] OFF_MODE = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFF_RD_ADDR = 8'h18;
   localparam logic [7:0] OFF_RD_LO = 8'h1C;
   localparam logic [7:0] OFF_RD_MID = 8'h20;
   localparam logic [7:0] OFF_RD_HI = 8'h24;
   localparam logic [7:0] OFF_POINTERS = 8'h28;
   // Control/status field positions
   localparam int BIT_ARM = 15;
   localparam int BIT_TRIG = 14;
   localparam int BIT_ACTIVE = 13;
   localparam int BIT_FULL = 12;
   // Mode field positions
   localparam int MODE_TIMED = 0;
   localparam int MODE_MARKER = 1;
   // Interrupt status bit positions
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_FULL = 1;
   // Reset values and bus response codes
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [31:0] INTERVAL_RST = 32'h0000_03E8;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [15:0] word2;
      logic [15:0] word1;
      logic [15:0] word0;
      logic [11:0] bits;
   } sample_t;

   typedef struct packed {
      logic marker;
      logic marker_skipped;
      logic program_end;
   } events_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLING = 2'b01,
      ST_RECORDING = 2'b10,
      ST_DONE = 2'b11
   } state_t;
endpackage

/* File: hw/trace_ram.sv */
// Trace memory, one write port and one registered read port
`timescale 1ns/1ps
module trace_ram (
   input wire logic aclk,
   input wire logic we,
   input wire logic [trace_pkg::AW-1:0] waddr,
   input wire trace_pkg::sample_t wdata,
   input wire logic [trace_pkg::AW-1:0] raddr,
   output trace_pkg::sample_t rdata
);
   trace_pkg::sample_t mem [trace_pkg::DEPTH];

   // Write and registered read
   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // trace_ram

/* File: hw/sync2.sv */
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // sync2

/* File: bench/program_model.sv */
// Program-side model: marker and cycle-end pulses with jump skip
`timescale 1ns/1ps
module program_model (
   input wire logic aclk,
   output logic marker,
   output logic pend,
   output logic skip
);
   initial begin
      marker = 1'b0;
      pend = 1'b0;
      skip = 1'b0;
   end
   // Four cycles high, five low between pulses, so the input sync sees each pulse
   task automatic run(input bit mk, input int n, input bit sk);
      skip <= sk;
      repeat (n) begin
         @(posedge aclk);
         if (mk) marker <= 1'b1;
         else pend <= 1'b1;
         repeat (4) @(posedge aclk);
         marker <= 1'b0;
         pend <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      skip <= 1'b0;
   endtask
endmodule // program_model

/* File: bench/trace_sampler_assertions.sv */
// Concurrent checks on the sampler's bus handshakes and flags
`timescale 1ns/1ps
module trace_sampler_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tracing_active_flag,
   input wire logic trace_full_flag,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Bus answers and refusals
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during data");
   a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   // Flag relations
   a_flags_apart: assert property (!(tracing_active_flag && trace_full_flag))
      else $error("active and full together");
   a_full_stop: assert property ($rose(trace_full_flag) |-> $fell(tracing_active_flag))
      else $error("full without end of tracing");
   a_full_hold: assert property ($rose(trace_full_flag) |-> ##1 trace_full_flag [*4])
      else $error("full flag dropped");
   c_full: cover property ($rose(trace_full_flag));
   c_irq: cover property ($rose(irq));
   c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule // trace_sampler_checker
bind trace_sampler trace_sampler_checker chk (.*);

/* File: bench/trace_memory_sampler_tb.sv */
// Self-checking bench for the trace memory sampler
`timescale 1ns/1ps
module trace_memory_sampler_tb;
   typedef struct packed {bit w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [31:0] awaddr, wdata, araddr, rdata, q;
   logic [1:0] bresp, rresp, r;
   logic ptrig, marker, pend, skip, active, full, irq;
   logic [3:0] wstrb;
   logic [11:0] tbits;
   int fail_count, n_compared;
   row_t rows [10];
   trace_sampler DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .trace_sample_point(marker), .jump_skip(skip), .program_end(pend),
      .program_trigger(ptrig), .trace_bits(tbits), .trace_word0(16'h1234), .trace_word1(16'h5678),
      .trace_word2(16'h9ABC), .tracing_active_flag(active), .trace_full_flag(full), .irq(irq));
   program_model pm (.aclk(aclk), .marker(marker), .pend(pend), .skip(skip));
   // Clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // Verdict and end of run
   task automatic conclude;
      $display("Counts: %0d mismatches, %0d comparisons", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus transfer; answer lands in q and r
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      int n;
      bit ta, tw, done;
      n = 0;
      done = 0;
      if (w) begin
         awaddr <= {24'h0, a};
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= {24'h0, a};
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      while (!done && n < 50) begin
         @(negedge aclk);
         ta = w ? awvalid && awready : arvalid && arready;
         tw = wvalid && wready;
         done = w ? bvalid : rvalid;
         q = rdata;
         r = w ? bresp : rresp;
         @(posedge aclk);
         if (w && ta) awvalid <= 1'b0;
         if (!w && ta) arvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      @(posedge aclk);
      if (!done) begin
         fail_count++;
         $display("Error at %0t: bus answer missing", $time);
         conclude();
      end
   endtask
   // Bounded wait for a flag to rise
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 5000) begin
         @(negedge aclk);
         n++;
      end
      if (s !== 1'b1) begin
         fail_count++;
         $display("Error at %0t: flag never rose", $time);
         conclude();
      end
      @(posedge aclk);
   endtask
   // Main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, ptrig} = 6'h00;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hF;
      tbits = 12'hA5C;
      fail_count = 0;
      n_compared = 0;
      rows = '{'{0, trace_pkg::OFF_CTRL, 0, 32'h0, 2'h0}, '{0, trace_pkg::OFF_DELAY, 0, 32'h0, 2'h0},
         '{0, trace_pkg::OFF_INTERVAL, 0, 32'h3E8, 2'h0}, '{0, trace_pkg::OFF_MODE, 0, 32'h0, 2'h0},
         '{0, trace_pkg::OFF_IRQ_STAT, 0, 32'h0, 2'h0}, '{0, 8'h2C, 0, 32'h0, 2'h2},
         '{1, 8'h2C, 32'h5, 32'h0, 2'h2}, '{1, trace_pkg::OFF_INTERVAL, 32'h4, 32'h0, 2'h0},
         '{0, trace_pkg::OFF_INTERVAL, 0, 32'h4, 2'h0}, '{1, trace_pkg::OFF_MODE, 32'h1, 32'h0, 2'h0}};
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(q, rows[i].e);
         chk({30'h0, r}, {30'h0, rows[i].r});
      end
      // Lane 1 strobe off leaves the arm bit alone
      wstrb <= 4'h1;
      bus(1, trace_pkg::OFF_CTRL, 32'h8000);
      wstrb <= 4'hF;
      bus(0, trace_pkg::OFF_CTRL, 0);
      chk(q, 32'h0);
      // Timed capture, trigger masked then unmasked
      bus(1, trace_pkg::OFF_CTRL, 32'h8000);
      bus(1, trace_pkg::OFF_CTRL, 32'hC000);
      q = 0;
      for (int i = 0; i < 10 && q[0] !== 1'b1; i++) bus(0, trace_pkg::OFF_IRQ_STAT, 0);
      chk(q, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1, trace_pkg::OFF_IRQ_MASK, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wait_hi(full);
      chk({30'h0, active, full}, 32'h1);
      bus(0, trace_pkg::OFF_IRQ_STAT, 0);
      chk(q, 32'h3);
      bus(1, trace_pkg::OFF_IRQ_STAT, 32'h3);
      bus(0, trace_pkg::OFF_IRQ_STAT, 0);
      chk({q[30:0], irq}, 32'h0);
      // Readback of one stored sample
      bus(1, trace_pkg::OFF_RD_ADDR, 32'h5);
      repeat (2) @(posedge aclk);
      bus(0, trace_pkg::OFF_RD_LO, 0);
      chk(q, 32'h1234_0A5C);
      bus(0, trace_pkg::OFF_RD_MID, 0);
      chk(q, 32'h5678);
      bus(0, trace_pkg::OFF_RD_HI, 0);
      chk(q, 32'h9ABC);
      // Trigger while disarmed starts nothing
      bus(1, trace_pkg::OFF_CTRL, 32'h0);
      ptrig <= 1'b1;
      repeat (8) @(posedge aclk);
      ptrig <= 1'b0;
      chk({31'h0, active}, 32'h0);
      // Marker mode: skipped markers and cycle ends take nothing
      tbits <= 12'h3C1;
      bus(1, trace_pkg::OFF_MODE, 32'h2);
      bus(1, trace_pkg::OFF_CTRL, 32'h8000);
      pm.run(1, 3, 0);
      pm.run(1, 2, 1);
      pm.run(0, 2, 0);
      bus(0, trace_pkg::OFF_POINTERS, 0);
      chk({24'h0, q[7:0]}, 32'h3);
      bus(1, trace_pkg::OFF_RD_ADDR, 32'h0);
      repeat (2) @(posedge aclk);
      bus(0, trace_pkg::OFF_RD_LO, 0);
      chk(q, 32'h1234_03C1);
      // Positive delay: two more samples before the trace starts
      bus(1, trace_pkg::OFF_DELAY, 32'h2);
      bus(1, trace_pkg::OFF_CTRL, 32'hC000);
      bus(0, trace_pkg::OFF_POINTERS, 0);
      chk(q, 32'h0002_0503);
      pm.run(1, 2, 0);
      bus(0, trace_pkg::OFF_POINTERS, 0);
      chk(q, 32'h0000_0505);
      chk({30'h0, active, full}, 32'h2);
      // Cycle-end mode, then program trigger with negative delay
      bus(1, trace_pkg::OFF_CTRL, 32'h0);
      bus(1, trace_pkg::OFF_MODE, 32'h0);
      bus(1, trace_pkg::OFF_CTRL, 32'h8000);
      pm.run(0, 4, 0);
      bus(0, trace_pkg::OFF_POINTERS, 0);
      chk({24'h0, q[7:0]}, 32'h4);
      bus(1, trace_pkg::OFF_DELAY, 32'hFFFD);
      ptrig <= 1'b1;
      wait_hi(active);
      ptrig <= 1'b0;
      bus(0, trace_pkg::OFF_POINTERS, 0);
      chk(q, 32'h0000_0104);
      // Reset in mid-trace, then release
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk({29'h0, active, full, irq}, 32'h0);
      @(posedge aclk);
      aresetn <= 1'b1;
      bus(0, trace_pkg::OFF_CTRL, 0);
      chk(q, 32'h0);
      bus(0, trace_pkg::OFF_DELAY, 0);
      chk(q, 32'h0);
      conclude();
   end
endmodule // trace_memory_sampler_tb
